// File: design/vrcs_sequencer.sv
// Purpose: nibble-wide command interpreter of a record/playback voice device
// Assumes: host inputs synchronous to clk; sampleTick pulses once per stored sample
// Notes:   address = {row[11:0], column[7:0]}; index area holds 8 channel entries
//
// Overview of operation
// - Voice data rows run 008h to FFFh; lower rows hold no voice.
// - Index write takes 8 nibbles LSB first: stop column, stop row, start row.
// - After index read, each read strobe returns the next of 8 address nibbles.
// - Status unreadable during index read; host waits busy after the last.
// - Width bit 0 selects 3-bit coding, 1 selects 4-bit coding.
// - Detect level 00 off, 01 supply/64, 10 supply/32, 11 supply/16.
// - Mode bit 0 is direct: channel from channel bits, count select ignored.
// - Direct record start loads stored start and stop into counter and stop register.
// - Recording ends when counter equals stop register; active flag clears.
// - Stop during recording stores counter as the new channel stop address.
// - Mode bit 1 selects fixed or flex by the two count select bits.
// - Fixed start loads generated addresses into counter, stop register, index.
// - Flex start uses previous stop plus one and memory end, saved to index.
// - Once flex recording reached memory end, no further channel may record; code refuses only a flex record start whose previous channel stops at row FFFh.
// - Playback ignores detect level and loads the stored channel addresses.
// - Playback ends at stop address; stop command does no address update.
// - Pause suspends, start resumes; while paused both flags read 1.
// - Start while paused resumes voice triggered recording without voice.
// - Stop while paused ends the operation and returns to standby.
// - With detection on, wait for voice: wait flag 1, then active flag.
// - Stop during voice wait ends the wait, staying in record standby.
// - Status nibble: bit3 full, bit2 wait, bit1 active, bit0 busy.
// - Busy reads high during reset processing and any command processing.
// - Active flag high while recording or playing; only stop, pause, resume.
// - Full flag clears on record mode, play mode or start command.
`timescale 1ns/1ps
`include "vrcs_cfg.svh"

module vrcs_sequencer
   import vrcs_pkg::*;
#(
   parameter logic [`VRCS_BUSY_W-1:0] BUSY_LONG_CYC = `VRCS_BUSY_W'(`VRCS_N_LONG)
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Host nibble bus
   input  wire logic [3:0]  hostData,
   input  wire logic        hostWr,
   input  wire logic        hostRd,
   output logic      [3:0]  hostRdData,
   // Audio path
   input  wire logic        sampleTick,
   input  wire logic        voiceDetect,
   // Settings and progress
   output logic      [1:0]  rateSel,
   output logic             bitLength4,
   output logic      [1:0]  detectLevel,
   output logic             recording,
   output logic             playing,
   output logic      [19:0] addrCount
);

   vrcs_state_t            state;
   vrcs_state_t            next_state;
   vrcs_phase_t            phase;
   vrcs_op_t               argOp;
   logic [2:0]             nibCnt;
   logic [27:0]            asmAddr;
   logic                   recMode;
   logic                   full;
   logic [`VRCS_BUSY_W-1:0] busyCnt;
   logic [1:0]             wordSel;
   logic [2:0]             chanSel;
   logic                   modeBit;
   logic [19:0]            stopReg;
   logic [31:0]            idxEntry [`VRCS_CHANNELS];

   // Host command decode
   wire vrcs_op_t op       = vrcs_op_t'(hostData);
   wire           busy     = (busyCnt != '0);
   wire           wrAcc    = hostWr && !busy;
   wire           opWr     = wrAcc && (phase == PH_OP);
   wire           argWr    = wrAcc && (phase == PH_ARG);
   wire           awrWr    = wrAcc && (phase == PH_AWR);
   wire           awrLast  = awrWr && (nibCnt == `VRCS_NIB_LAST);
   wire           ardRd    = hostRd && (phase == PH_ARD);
   wire           ardLast  = ardRd && (nibCnt == `VRCS_NIB_LAST);
   wire           running  = (state == VRCS_ACTIVE) || (state == VRCS_PAUSED);
   wire           opOk     = (state == VRCS_IDLE)
                           || (op == OP_STOP)
                           || (op == OP_PAUSE && state == VRCS_ACTIVE)
                           || (op == OP_START && state == VRCS_PAUSED);
   wire           opTake   = opWr && opOk;
   wire           startIdle = opTake && op == OP_START && state == VRCS_IDLE;
   wire           resume   = opTake && op == OP_START && state == VRCS_PAUSED;
   wire           doStop   = opTake && op == OP_STOP && state != VRCS_IDLE;
   wire           doPause  = opTake && op == OP_PAUSE && state == VRCS_ACTIVE;
   wire           argNext  = opTake && (op == OP_RATE || op == OP_CHANNEL_SELECT_CMD || op == OP_DETECT);

   // Control mode and address generation
   wire        flexMode  = modeBit && (wordSel == 2'h3);
   wire        fixedMode = modeBit && !flexMode;
   wire [7:0]  yLast     = bitLength4 ? `VRCS_Y_LAST_4B : `VRCS_Y_LAST_3B;
   wire [19:0] memEnd    = {`VRCS_VOICE_X_LAST, yLast};
   wire [2:0]  chanEff   = !fixedMode ? chanSel :
                           (wordSel == 2'h1) ? {1'b0, chanSel[1:0]} :
                           (wordSel == 2'h2) ? {2'h0, chanSel[0]} : chanSel;
   wire [11:0] fixRows   = (wordSel == 2'h1) ? `VRCS_ROWS_4W :
                           (wordSel == 2'h2) ? `VRCS_ROWS_2W : `VRCS_ROWS_8W;
   wire [11:0] fixStartX = `VRCS_VOICE_X_FIRST + 12'(chanEff * fixRows);
   wire [19:0] fixStop   = {12'(fixStartX + fixRows - 12'h001), yLast};
   wire [31:0] curEntry  = idxEntry[chanEff];
   wire [31:0] prevEntry = idxEntry[3'(chanSel - 3'h1)];
   wire [11:0] prevStopX = prevEntry[`VRCS_ENT_STOP_MSB -: 12];
   wire        flexFirst = (chanSel == 3'h0);
   wire [11:0] flexStartX = flexFirst ? `VRCS_VOICE_X_FIRST : 12'(prevStopX + 12'h001);
   wire        flexNoRoom = !flexFirst && (prevStopX == `VRCS_VOICE_X_LAST);
   wire        genRec    = recMode && modeBit;
   wire [11:0] loadStartX = (recMode && flexMode)  ? flexStartX :
                            (recMode && fixedMode) ? fixStartX :
                            curEntry[31:`VRCS_ENT_START_LSB];
   wire [19:0] loadStop  = (recMode && flexMode)  ? memEnd :
                           (recMode && fixedMode) ? fixStop :
                           curEntry[`VRCS_ENT_STOP_MSB:0];
   wire        refuse    = startIdle && recMode && flexMode && flexNoRoom;
   wire        loadGo    = startIdle && !refuse;
   wire        endHit    = (state == VRCS_ACTIVE) && (addrCount == stopReg);
   wire        stopUpd   = doStop && recMode && running;
   wire [19:0] addrStep  = (addrCount[7:0] == yLast) ?
                           {12'(addrCount[19:8] + 12'h001), 8'h00} :
                           20'(addrCount + 20'h00001);

   // Index area write port
   wire        idxWrEn   = awrLast || (loadGo && genRec) || stopUpd;
   wire [31:0] idxWrData = awrLast ? {hostData, asmAddr} :
                           stopUpd ? {curEntry[31:`VRCS_ENT_START_LSB], addrCount} :
                           {loadStartX, loadStop};

   // Status
   wire        fullSet   = (endHit && recMode && flexMode && stopReg == memEnd) || refuse;
   wire        fullClr   = opTake && (op == OP_REC || op == OP_PLAY || op == OP_START);
   wire        suspFlag  = (state == VRCS_VWAIT) || (state == VRCS_PAUSED);
   wire [3:0]  statusNib = {full, suspFlag, running, busy};
   wire [31:0] rdEntry   = idxEntry[chanEff];
   wire [3:0]  rdNib     = rdEntry[{nibCnt, 2'h0} +: 4];

   assign recording = running && recMode;
   assign playing   = running && !recMode;

   genvar gi;
   generate
      for (gi = 0; gi < `VRCS_CHANNELS; gi++) begin : g_idx
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               idxEntry[gi] <= `VRCS_RST_ENTRY;
            end else if (idxWrEn && chanEff == 3'(gi)) begin
               idxEntry[gi] <= idxWrData;
            end
         end
      end
   endgenerate

   always_comb begin
      next_state = state;
      case (state)
         VRCS_IDLE: begin
            if (loadGo) begin
               next_state = (recMode && detectLevel != DET_OFF) ? VRCS_VWAIT : VRCS_ACTIVE;
            end
         end
         VRCS_VWAIT: begin
            if (doStop) begin
               next_state = VRCS_IDLE;
            end else if (voiceDetect) begin
               next_state = VRCS_ACTIVE;
            end
         end
         VRCS_ACTIVE: begin
            if (doStop || endHit) begin
               next_state = VRCS_IDLE;
            end else if (doPause) begin
               next_state = VRCS_PAUSED;
            end
         end
         VRCS_PAUSED: begin
            if (doStop) begin
               next_state = VRCS_IDLE;
            end else if (resume) begin
               next_state = VRCS_ACTIVE;
            end
         end
         default: next_state = VRCS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= VRCS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Busy timer: reset, command and address nibble intervals
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busyCnt <= `VRCS_BUSY_W'(`VRCS_N_RESET);
      end else if (opTake && (op == OP_INDEX_ADDRESS_WRITE_CMD || op == OP_INDEX_ADDRESS_READ_CMD)) begin
         busyCnt <= BUSY_LONG_CYC;
      end else if (opTake || argWr) begin
         busyCnt <= `VRCS_BUSY_W'(`VRCS_N_CMD);
      end else if (awrWr || ardRd) begin
         busyCnt <= `VRCS_BUSY_W'(`VRCS_N_ADDR);
      end else if (busy) begin
         busyCnt <= busyCnt - `VRCS_BUSY_W'(1);
      end
   end

   // Command phase and nibble position
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase  <= PH_OP;
         nibCnt <= 3'h0;
         argOp  <= OP_NOP;
      end else begin
         if (argNext) begin
            phase <= PH_ARG;
            argOp <= op;
         end else if (opTake && op == OP_INDEX_ADDRESS_WRITE_CMD) begin
            phase <= PH_AWR;
         end else if (opTake && op == OP_INDEX_ADDRESS_READ_CMD) begin
            phase <= PH_ARD;
         end else if (argWr || awrLast || ardLast) begin
            phase <= PH_OP;
         end
         if (awrLast || ardLast) begin
            nibCnt <= 3'h0;
         end else if (awrWr || ardRd) begin
            nibCnt <= nibCnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         asmAddr <= 28'h0000000;
      end else if (awrWr && !awrLast) begin
         asmAddr[{nibCnt, 2'h0} +: 4] <= hostData;
      end
   end

   // Argument nibbles
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rateSel     <= `VRCS_RST_RATE;
         wordSel     <= `VRCS_RST_WSEL;
         bitLength4  <= `VRCS_RST_WIDTH;
         detectLevel <= `VRCS_RST_DETECT;
         chanSel     <= `VRCS_RST_CHANNEL_SELECT_CMD;
         modeBit     <= `VRCS_RST_MODE;
      end else if (argWr) begin
         case (argOp)
            OP_RATE: begin
               wordSel <= hostData[3:2];
               rateSel <= hostData[1:0];
            end
            OP_CHANNEL_SELECT_CMD: begin
               modeBit <= hostData[`VRCS_CHANNEL_SELECT_CMD_MODE_BIT];
               chanSel <= hostData[2:0];
            end
            OP_DETECT: begin
               bitLength4  <= hostData[`VRCS_VDS_WIDTH_BIT];
               detectLevel <= hostData[1:0];
            end
            default: ;
         endcase
      end
   end

   // Address counter, stop register, mode and full flag
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         addrCount <= 20'h00000;
         stopReg   <= 20'h00000;
         recMode   <= 1'b0;
         full      <= 1'b0;
      end else begin
         if (loadGo) begin
            addrCount <= {loadStartX, 8'h00};
            stopReg   <= loadStop;
         end else if (state == VRCS_ACTIVE && sampleTick && !endHit) begin
            addrCount <= addrStep;
         end
         if (opTake && op == OP_REC) begin
            recMode <= 1'b1;
         end else if (opTake && op == OP_PLAY) begin
            recMode <= 1'b0;
         end
         if (fullSet) begin
            full <= 1'b1;
         end else if (fullClr) begin
            full <= 1'b0;
         end
      end
   end

   // Read strobe answers one cycle later: address nibble or status
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hostRdData <= 4'h0;
      end else if (hostRd) begin
         hostRdData <= (phase == PH_ARD) ? rdNib : statusNib;
      end else begin
         hostRdData <= 4'h0;
      end
   end

   a_status_nibble: assert property (@(posedge clk) disable iff (sys_rst)
      hostRd && phase != PH_ARD |=> hostRdData == $past(statusNib))
      else $error("status nibble wrong");
   a_read_nibble: assert property (@(posedge clk) disable iff (sys_rst)
      ardRd |=> hostRdData == $past(rdNib) && phase == (($past(nibCnt) == 3'h7) ? PH_OP : PH_ARD))
      else $error("address read nibble wrong");
   a_busy_after_cmd: assert property (@(posedge clk) disable iff (sys_rst)
      opTake |=> busy [*8])
      else $error("busy not held after command");
   a_pause_flags: assert property (@(posedge clk) disable iff (sys_rst)
      doPause |=> statusNib[2:1] == 2'h3 && state == VRCS_PAUSED)
      else $error("pause flags wrong");
   a_voice_wait: assert property (@(posedge clk) disable iff (sys_rst)
      state == VRCS_VWAIT && voiceDetect && !doStop |=> state == VRCS_ACTIVE && !suspFlag)
      else $error("voice wait not ended on voice");
   a_end_stop: assert property (@(posedge clk) disable iff (sys_rst)
      endHit |=> state == VRCS_IDLE && !running)
      else $error("operation did not end at stop address");
   a_stop_store: assert property (@(posedge clk) disable iff (sys_rst)
      stopUpd |=> idxEntry[$past(chanEff)][19:0] == $past(addrCount))
      else $error("stop address not stored");
   a_index_write: assert property (@(posedge clk) disable iff (sys_rst)
      awrLast |=> idxEntry[$past(chanEff)] == {$past(hostData), $past(asmAddr)} && nibCnt == 3'h0)
      else $error("index write wrong");
   a_direct_load: assert property (@(posedge clk) disable iff (sys_rst)
      loadGo && !genRec |=> addrCount == {$past(curEntry[31:20]), 8'h00}
                            && stopReg == $past(curEntry[19:0]))
      else $error("stored addresses not loaded");
   a_full_clear: assert property (@(posedge clk) disable iff (sys_rst)
      fullClr && !fullSet |=> !full)
      else $error("full flag not cleared");
   a_width_sel: assert property (@(posedge clk) disable iff (sys_rst)
      argWr && argOp == OP_DETECT |=> bitLength4 == $past(hostData[2]))
      else $error("coding width not taken");
   a_gen_index: assert property (@(posedge clk) disable iff (sys_rst)
      loadGo && genRec |=> idxEntry[$past(chanEff)] == {addrCount[19:8], stopReg}
                           && addrCount[7:0] == 8'h00)
      else $error("generated addresses not saved to index");
   a_flex_start: assert property (@(posedge clk) disable iff (sys_rst)
      loadGo && recMode && flexMode |=> stopReg[19:8] == `VRCS_VOICE_X_LAST
         && addrCount[19:8] == ($past(flexFirst) ? `VRCS_VOICE_X_FIRST
                                                 : 12'($past(prevStopX) + 12'h001)))
      else $error("flex addresses wrong");
   a_flex_refuse: assert property (@(posedge clk) disable iff (sys_rst)
      refuse |=> full && state == VRCS_IDLE)
      else $error("flex start not refused at memory end");
   a_play_stop: assert property (@(posedge clk) disable iff (sys_rst)
      doStop && !recMode |-> !idxWrEn)
      else $error("playback stop touched the index area");
   a_resume_go: assert property (@(posedge clk) disable iff (sys_rst)
      resume |=> state == VRCS_ACTIVE)
      else $error("start did not resume");

   c_record_end: cover property (@(posedge clk) disable iff (sys_rst) endHit && recMode);
   c_pause_resume: cover property (@(posedge clk) disable iff (sys_rst) resume);
   c_read_done: cover property (@(posedge clk) disable iff (sys_rst) ardLast);
   c_flex_full: cover property (@(posedge clk) disable iff (sys_rst) fullSet);
   c_fixed_start: cover property (@(posedge clk) disable iff (sys_rst) loadGo && fixedMode);

endmodule

// File: design/vrcs_cfg.svh
// Purpose: constants of the voice recorder command sequencer
// Assumes: 20 MHz system clock
// Notes:   timing counts derive from times in microseconds
`ifndef VRCS_CFG_SVH
`define VRCS_CFG_SVH

`define VRCS_CLK_MHZ      20
`define VRCS_T_RESET_US   125
`define VRCS_T_CMD_US     16
`define VRCS_T_ADDR_US    50
`define VRCS_T_LONG_US    270
`define VRCS_N_RESET      (`VRCS_T_RESET_US * `VRCS_CLK_MHZ)
`define VRCS_N_CMD        (`VRCS_T_CMD_US * `VRCS_CLK_MHZ)
`define VRCS_N_ADDR       (`VRCS_T_ADDR_US * `VRCS_CLK_MHZ)
`define VRCS_N_LONG       (`VRCS_T_LONG_US * `VRCS_CLK_MHZ)
`define VRCS_BUSY_W       13

`define VRCS_CHANNELS     8
`define VRCS_NIB_LAST     3'h7
`define VRCS_VOICE_X_FIRST 12'h008
`define VRCS_VOICE_X_LAST 12'hFFF
`define VRCS_Y_LAST_3B    8'hA9
`define VRCS_Y_LAST_4B    8'h7F
`define VRCS_ROWS_8W      12'h1FF
`define VRCS_ROWS_4W      12'h3FE
`define VRCS_ROWS_2W      12'h7FC

// Index entry layout: start row above the 20-bit stop address
`define VRCS_ENT_START_LSB 20
`define VRCS_ENT_STOP_MSB  19

// Argument nibble field positions
`define VRCS_VDS_WIDTH_BIT 2
`define VRCS_CHANNEL_SELECT_CMD_MODE_BIT 3

// Reset values
`define VRCS_RST_RATE     2'h0
`define VRCS_RST_WSEL     2'h0
`define VRCS_RST_WIDTH    1'b0
`define VRCS_RST_DETECT   2'h0
`define VRCS_RST_CHANNEL_SELECT_CMD     3'h0
`define VRCS_RST_MODE     1'b0
`define VRCS_RST_ENTRY    32'h0000_0000

`endif

// File: design/vrcs_pkg.sv
// Purpose: types of the voice recorder command sequencer
// Assumes: nothing beyond the constants header
// Notes:   opcodes are the 4-bit first nibble of each command
package vrcs_pkg;

   typedef enum logic [3:0] {
      VRCS_IDLE   = 4'h1,
      VRCS_VWAIT  = 4'h2,
      VRCS_ACTIVE = 4'h4,
      VRCS_PAUSED = 4'h8
   } vrcs_state_t;

   typedef enum logic [3:0] {
      PH_OP  = 4'h1,
      PH_ARG = 4'h2,
      PH_AWR = 4'h4,
      PH_ARD = 4'h8
   } vrcs_phase_t;

   typedef enum logic [3:0] {
      OP_NOP    = 4'h0,
      OP_PAUSE  = 4'h1,
      OP_PLAY   = 4'h2,
      OP_REC    = 4'h3,
      OP_START  = 4'h4,
      OP_STOP   = 4'h5,
      OP_RATE   = 4'h6,
      OP_CHANNEL_SELECT_CMD   = 4'h7,
      OP_INDEX_ADDRESS_WRITE_CMD  = 4'h8,
      OP_INDEX_ADDRESS_READ_CMD  = 4'h9,
      OP_XFER   = 4'hA,
      OP_EXTIO  = 4'hB,
      OP_DETECT = 4'hC
   } vrcs_op_t;

   typedef enum logic [1:0] {
      DET_OFF = 2'h0,
      DET_64  = 2'h1,
      DET_32  = 2'h2,
      DET_16  = 2'h3
   } vrcs_detect_t;

endpackage

// File: testbench/vrcs_host_model.sv
// Purpose: host microcontroller model on the nibble bus
// Assumes: strobes change by non-blocking assignment after a rising edge
// Notes:   released data lines show the inverse of the last nibble
`timescale 1ns/1ps
module vrcs_host_model #(
   parameter int LONG_WAIT = 45
) (
   // Clock
   input  wire logic       clk,
   // Nibble bus
   output logic      [3:0] hostData,
   output logic            hostWr,
   output logic            hostRd,
   input  wire logic [3:0] hostRdData
);
   initial begin
      hostData = 4'h0;
      hostWr   = 1'b0;
      hostRd   = 1'b0;
   end

   task automatic wrNib(input logic [3:0] d);
      @(posedge clk);
      hostData <= d;
      hostWr   <= 1'b1;
      @(posedge clk);
      hostWr   <= 1'b0;
      hostData <= ~d;
   endtask

   // Answer stands only in the cycle after the strobe
   task automatic rdNib(output logic [3:0] d);
      @(posedge clk);
      hostRd <= 1'b1;
      @(posedge clk);
      hostRd <= 1'b0;
      @(negedge clk);
      d = hostRdData;
   endtask

   // Poll busy before any command or nibble
   task automatic waitIdle(output logic ok);
      logic [3:0] s;
      ok = 1'b0;
      for (int i = 0; i < 4000 && !ok; i++) begin
         rdNib(s);
         ok = (s[0] === 1'b0);
      end
   endtask

   // Status is hidden during index read, so fixed waits are used
   task automatic idxRead(output logic [31:0] e);
      logic [3:0] n;
      repeat (LONG_WAIT) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
         rdNib(n);
         e[4*k+:4] = n;
         repeat (1005) @(posedge clk);
      end
   endtask
endmodule

// File: testbench/vrcs_sequencer_tb.sv
// Purpose: self-checking bench of the command sequencer
// Assumes: short index-command busy through BUSY_LONG_CYC
// Notes:   channel 2 direct carries most traffic; channels 1, 3 and 4 try fixed and flex
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin failCount++; \
   $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module vrcs_sequencer_tb;
   import vrcs_pkg::*;
   localparam logic [12:0] LONG = 13'h0028;
   logic        clk = 1'b0;
   logic        sysRst = 1'b1;
   logic [3:0]  hostData;
   logic        hostWr;
   logic        hostRd;
   logic [3:0]  hostRdData;
   logic        sampleTick = 1'b0;
   logic        voiceDetect = 1'b0;
   logic [1:0]  rateSel;
   logic        bitLength4;
   logic [1:0]  detectLevel;
   logic        recording;
   logic        playing;
   logic [19:0] addrCount;
   int          failCount = 0;
   int          samplesChecked = 0;

   always #25 clk = ~clk;

   vrcs_sequencer #(.BUSY_LONG_CYC(LONG)) vrcs_sequencer_i (.clk(clk), .sys_rst(sysRst),
      .hostData(hostData), .hostWr(hostWr), .hostRd(hostRd), .hostRdData(hostRdData),
      .sampleTick(sampleTick), .voiceDetect(voiceDetect), .rateSel(rateSel),
      .bitLength4(bitLength4), .detectLevel(detectLevel), .recording(recording),
      .playing(playing), .addrCount(addrCount));
   vrcs_host_model #(.LONG_WAIT(45)) vrcs_host_model_i (.clk(clk), .hostData(hostData),
      .hostWr(hostWr), .hostRd(hostRd), .hostRdData(hostRdData));

   task automatic endSim;
      $display("checks %0d, mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic idle;
      logic ok;
      vrcs_host_model_i.waitIdle(ok);
      `CHK(ok, 1'b1)
   endtask
   task automatic cmd(input logic [3:0] n);
      idle();
      vrcs_host_model_i.wrNib(n);
   endtask
   task automatic stat(input logic [3:0] exp);
      logic [3:0] s;
      vrcs_host_model_i.rdNib(s);
      `CHK(s, exp)
   endtask
   task automatic idxCheck(input logic [31:0] exp);
      logic [31:0] e;
      cmd(OP_INDEX_ADDRESS_READ_CMD);
      vrcs_host_model_i.idxRead(e);
      `CHK(e, exp)
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk) sampleTick <= 1'b1;
         @(posedge clk) sampleTick <= 1'b0;
      end
   endtask

   task automatic tReset;
      stat(4'h1);
      idle();
      `CHK({rateSel, bitLength4, detectLevel, addrCount}, 25'h0)
   endtask
   task automatic tSettings;
      for (int i = 0; i < 8; i++) begin
         cmd(OP_DETECT);
         cmd(4'(i));
         idle();
         `CHK({bitLength4, detectLevel}, 3'(i))
      end
      cmd(OP_DETECT);
      cmd(4'h0);
      cmd(OP_RATE);
      cmd(4'hE);
      cmd(OP_CHANNEL_SELECT_CMD);
      cmd(4'h2);
      idle();
      `CHK(rateSel, 2'h2)
   endtask
   task automatic tIndex;
      logic [31:0] e = 32'h0080_0803;
      cmd(OP_INDEX_ADDRESS_WRITE_CMD);
      for (int k = 0; k < 8; k++)
         cmd(e[4*k+:4]);
      idxCheck(e);
   endtask
   task automatic tRecord;
      cmd(OP_REC);
      cmd(OP_START);
      idle();
      `CHK({recording, addrCount}, 21'h10_0800)
      stat(4'h2);
      tick(3);
      repeat (2) @(posedge clk);
      `CHK({recording, addrCount}, 21'h00_0803)
      cmd(OP_START);
      tick(1);
      cmd(OP_PAUSE);
      idle();
      stat(4'h6);
      cmd(OP_START);
      idle();
      tick(1);
      cmd(OP_STOP);
      idle();
      `CHK(recording, 1'b0)
      idxCheck(32'h0080_0802);
   endtask
   task automatic tPlay;
      cmd(OP_DETECT);
      cmd(4'h1);
      cmd(OP_PLAY);
      cmd(OP_START);
      idle();
      `CHK({playing, addrCount}, 21'h10_0800)
      cmd(OP_PAUSE);
      idle();
      stat(4'h6);
      cmd(OP_STOP);
      idle();
      `CHK(playing, 1'b0)
      stat(4'h0);
      idxCheck(32'h0080_0802);
   endtask
   task automatic tVoice;
      cmd(OP_REC);
      cmd(OP_START);
      idle();
      stat(4'h4);
      cmd(OP_STOP);
      idle();
      stat(4'h0);
      cmd(OP_START);
      idle();
      stat(4'h4);
      @(posedge clk) voiceDetect <= 1'b1;
      repeat (3) @(posedge clk);
      stat(4'h2);
      `CHK(recording, 1'b1)
      @(posedge clk) voiceDetect <= 1'b0;
      cmd(OP_PAUSE);
      cmd(OP_START);
      idle();
      stat(4'h2);
      cmd(OP_STOP);
      idle();
   endtask
   task automatic tModes;
      logic [31:0] e = 32'h009F_FF7F;
      cmd(OP_DETECT);
      cmd(4'h4);
      cmd(OP_RATE);
      cmd(4'hC);
      cmd(OP_CHANNEL_SELECT_CMD);
      cmd(4'hB);
      cmd(OP_START);
      idle();
      `CHK({recording, addrCount}, 21'h10_0900)
      cmd(OP_STOP);
      cmd(OP_INDEX_ADDRESS_WRITE_CMD);
      for (int k = 0; k < 8; k++)
         cmd(e[4*k+:4]);
      cmd(OP_CHANNEL_SELECT_CMD);
      cmd(4'hC);
      cmd(OP_START);
      idle();
      stat(4'h8);
      cmd(OP_REC);
      idle();
      stat(4'h0);
      cmd(OP_RATE);
      cmd(4'h4);
      cmd(OP_CHANNEL_SELECT_CMD);
      cmd(4'hD);
      cmd(OP_START);
      idle();
      `CHK({recording, addrCount}, 21'h14_0600)
      cmd(OP_STOP);
      idle();
   endtask

   initial begin
      repeat (10) @(posedge clk);
      sysRst <= 1'b0;
      tReset();
      tSettings();
      tIndex();
      tRecord();
      tPlay();
      tVoice();
      tModes();
      endSim();
   end

   initial begin
      repeat (95000) @(posedge clk);
      failCount++;
      endSim();
   end
endmodule
